// File: shared/tone_regs.svh
`ifndef TONE_REGS_SVH
`define TONE_REGS_SVH

// ---------------------------------------------------------------
// Tone command fields
// ---------------------------------------------------------------
`define CMD_DUR_HI 7
`define CMD_DUR_LO 5
`define CMD_FRQ_HI 4
`define CMD_FRQ_LO 1
`define CMD_LVL_BIT 1
`define CMD_QSEL_BIT 0
`define CMD_RESET 8'h00

// Duration codes
`define DUR_CONT 3'h0
`define DUR_AUTO_SUB 3'h7

// Frequency/level codes
`define FRQ_LOW 4'h0
`define FRQ_HIGH 4'h1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_HZ 10000000
`define MS_PER_S 1000
`define HALF_SCALE 50

// Durations in ms, as printed
`define DUR1_MS 15625
`define DUR2_MS 3125
`define DUR3_MS 625
`define DUR4_MS 125
`define DUR5_MS 250
`define DUR6_MS 500
`define DUR7_MS 1000

// Tone frequencies in hundredths of a hertz
`define F2_CHZ 52325
`define F3_CHZ 58733
`define F4_CHZ 65926
`define F5_CHZ 69846
`define F6_CHZ 78399
`define F7_CHZ 88000
`define F8_CHZ 98777
`define F9_CHZ 104650
`define FA_CHZ 131850
`define FB_CHZ 156800
`define FC_CHZ 176000
`define FD_CHZ 209300
`define FE_CHZ 234930
`define FF_CHZ 263700

// Output pin groups
`define GPO_INT_BIT 6
`define MATRIX_LINES 16

`endif

// File: shared/tone_pkg.sv
package tone_pkg;

   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_IDLE = 2'b01,
      ST_PLAY = 2'b10
   } state_e;

   typedef struct packed {
      state_e state;
      logic [7:0] act_cmd;
      logic act_auto;
      logic [7:0] q_cmd;
      logic q_valid;
      logic q_auto;
      logic snd;
      logic [15:0] half_cnt;
      logic [15:0] ms_cnt;
      logic [13:0] dur_cnt;
      logic stop_pend;
      logic wr_ack;
      logic wr_nack;
      logic [7:0] rd_data;
      logic [6:0] general_purpose_output;
      logic int_n;
      logic alert_status;
      logic irq;
      logic keyscan_en;
      logic kfifo_clr;
      logic [15:0] matrix_oe_n;
   } state_s;

endpackage

// File: verilog/tone_sounder.sv
`timescale 1ns/1ps
`include "tone_regs.svh"

module tone_sounder #(
   parameter int unsigned MS_TICK_CYCLES = `CLK_HZ / `MS_PER_S
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Host sounder access
   input wire logic wr_stb_i,
   input wire logic [7:0] wr_data_i,
   output logic wr_ack_o,
   output logic wr_nack_o,
   output logic [7:0] rd_data_o,
   // Automatic alert / key sounds
   input wire logic auto_stb_i,
   input wire logic [7:0] auto_cmd_i,
   // Configuration
   input wire logic cfg_wr_i,
   input wire logic run_not_sleep_bit_i,
   output logic keyscan_en_o,
   output logic keyscan_fifo_clr_o,
   // Key matrix lines
   output logic [15:0] matrix_line_oe_n_o,
   // Alert and interrupt
   input wire logic alert_i,
   input wire logic alert_irq_en_i,
   input wire logic irq_clr_i,
   output logic alert_status_o,
   output logic irq_req_o,
   // General-purpose outputs
   input wire logic gpo_wr_i,
   input wire logic [6:0] gpo_data_i,
   input wire logic int_gpo_sel_i,
   output logic [6:0] general_purpose_output_o,
   output logic int_n_o,
   // Sounder
   output logic sounder_o
);
   import tone_pkg::*;

   // ---------------------------------------------------------------
   // Lookup functions
   // ---------------------------------------------------------------

   // Half period of each tone in clock cycles
   // Integer division truncates: the tone runs a hair sharp,
   // never flat, and the error stays below one clock cycle
   function automatic logic [15:0] half_cycles(input logic [3:0] code);
      int unsigned f;
      f = `FF_CHZ;
      unique case (code)
         4'h2: f = `F2_CHZ;
         4'h3: f = `F3_CHZ;
         4'h4: f = `F4_CHZ;
         4'h5: f = `F5_CHZ;
         4'h6: f = `F6_CHZ;
         4'h7: f = `F7_CHZ;
         4'h8: f = `F8_CHZ;
         4'h9: f = `F9_CHZ;
         4'hA: f = `FA_CHZ;
         4'hB: f = `FB_CHZ;
         4'hC: f = `FC_CHZ;
         4'hD: f = `FD_CHZ;
         4'hE: f = `FE_CHZ;
         4'hF: f = `FF_CHZ;
         default: f = `FF_CHZ;
      endcase
      return 16'((`CLK_HZ * `HALF_SCALE) / f);
   endfunction

   // Duration in ms for a duration code
   // Code zero means no timer at all; the caller tests for it
   function automatic logic [13:0] dur_ms(input logic [2:0] code);
      logic [13:0] d;
      d = 14'h0000;
      unique case (code)
         3'h1: d = 14'(`DUR1_MS);
         3'h2: d = 14'(`DUR2_MS);
         3'h3: d = 14'(`DUR3_MS);
         3'h4: d = 14'(`DUR4_MS);
         3'h5: d = 14'(`DUR5_MS);
         3'h6: d = 14'(`DUR6_MS);
         3'h7: d = 14'(`DUR7_MS);
         default: d = 14'h0000;
      endcase
      return d;
   endfunction

   // Load a command as the active one
   // Timers restart from zero, so a new command never inherits
   // a part-used millisecond or half period from the old one
   function automatic state_s start_cmd(input state_s s, input logic [7:0] cmd,
                                        input logic is_auto);
      state_s t;
      logic [7:0] c;
      logic [3:0] frq;
      t = s;
      c = cmd;
      if (is_auto && c[`CMD_DUR_HI:`CMD_DUR_LO] == `DUR_CONT) begin
         c[`CMD_DUR_HI:`CMD_DUR_LO] = `DUR_AUTO_SUB;
      end
      frq = c[`CMD_FRQ_HI:`CMD_FRQ_LO];
      t.state = ST_PLAY;
      t.act_cmd = c;
      t.act_auto = is_auto;
      t.half_cnt = 16'h0000;
      t.ms_cnt = 16'h0000;
      t.dur_cnt = dur_ms(c[`CMD_DUR_HI:`CMD_DUR_LO]);
      t.stop_pend = 1'b0;
      // Level codes drive the level, tones open with the high half
      if (frq == `FRQ_LOW || frq == `FRQ_HIGH) begin
         t.snd = frq[0];
      end else begin
         t.snd = 1'b1;
      end
      return t;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   state_s r_reg;
   state_s r_next;

   logic [3:0] act_frq;
   logic act_is_level;
   logic act_cont;
   logic ms_tick;
   logic expired;
   logic half_done;
   logic cycle_end;
   logic finish;
   logic auto_lock;

   // ---------------------------------------------------------------
   // Active command decode
   // ---------------------------------------------------------------
   // Fields of the active command
   assign act_frq = r_reg.act_cmd[`CMD_FRQ_HI:`CMD_FRQ_LO];
   assign act_is_level = (act_frq == `FRQ_LOW) || (act_frq == `FRQ_HIGH);
   assign act_cont = (r_reg.act_cmd[`CMD_DUR_HI:`CMD_DUR_LO] == `DUR_CONT);

   // Host writes stay locked while any automatic sound is live
   assign auto_lock = (r_reg.state == ST_PLAY && r_reg.act_auto) || r_reg.q_auto;

   // Millisecond tick and expiry of the duration
   assign ms_tick = (r_reg.ms_cnt == 16'(MS_TICK_CYCLES - 1));
   assign expired = ms_tick && !act_cont && (r_reg.dur_cnt == 14'h0001);
   assign half_done = (r_reg.half_cnt == half_cycles(act_frq) - 16'h0001);

   // Cycle ends as the low half runs out
   assign cycle_end = half_done && !r_reg.snd;
   assign finish = (r_reg.state == ST_PLAY) &&
                   (act_is_level ? expired
                                 : ((r_reg.stop_pend || expired) && cycle_end));

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   // Priority runs top to bottom: host write, then automatic
   // sound, then the run bit, so sleep always has the last word
   always_comb begin
      r_next = r_reg;
      if (ce_i) begin
         // One-cycle answers, held while the enable is low
         r_next.wr_ack = 1'b0;
         r_next.wr_nack = 1'b0;
         r_next.kfifo_clr = 1'b0;

         // Alert status and interrupt, live in every mode
         r_next.alert_status = alert_i;
         r_next.irq = (r_reg.irq && !irq_clr_i) ||
                      (alert_i && !r_reg.alert_status && alert_irq_en_i);


         // General-purpose outputs, any mode
         if (gpo_wr_i) begin
            r_next.general_purpose_output = gpo_data_i;
         end


         // Tone engine
         if (r_reg.state == ST_PLAY) begin
            // Millisecond prescaler and duration countdown
            r_next.ms_cnt = ms_tick ? 16'h0000 : r_reg.ms_cnt + 16'h0001;
            if (ms_tick && !act_cont && r_reg.dur_cnt != 14'h0000) begin
               r_next.dur_cnt = r_reg.dur_cnt - 14'h0001;
            end
            // Expiry arms the stop; tones run to the cycle end, level codes stop at once
            if (expired) begin
               r_next.stop_pend = 1'b1;
            end
            // Level codes hold the pin, tones toggle each half period
            if (!act_is_level) begin
               r_next.half_cnt = half_done ? 16'h0000 : r_reg.half_cnt + 16'h0001;
               if (half_done) begin
                  r_next.snd = !r_reg.snd;
               end
            end
            // A finished command hands over to the queued one at once
            if (finish) begin
               r_next.snd = 1'b0;
               r_next.state = ST_IDLE;
               r_next.act_auto = 1'b0;
               r_next.act_cmd = `CMD_RESET;
               if (r_reg.q_valid) begin
                  r_next = start_cmd(r_next, r_reg.q_cmd, r_reg.q_auto);
                  r_next.q_valid = 1'b0;
                  r_next.q_auto = 1'b0;
               end
            end
         end


         // Host write to the sounder
         // A refused write leaves queue and engine untouched
         if (wr_stb_i) begin
            if (r_reg.state == ST_SLEEP) begin
               r_next.wr_ack = 1'b1;
            end else if (auto_lock || auto_stb_i) begin
               r_next.wr_nack = 1'b1;
            end else begin
               r_next.wr_ack = 1'b1;
               if (!wr_data_i[`CMD_QSEL_BIT] ||
                   wr_data_i[`CMD_FRQ_HI:`CMD_FRQ_LO] == `FRQ_LOW ||
                   wr_data_i[`CMD_FRQ_HI:`CMD_FRQ_LO] == `FRQ_HIGH) begin
                  r_next = start_cmd(r_next, wr_data_i, 1'b0);
                  r_next.q_valid = 1'b0;
                  r_next.q_auto = 1'b0;
               end else if (r_next.state == ST_PLAY) begin
                  r_next.q_cmd = wr_data_i;
                  r_next.q_valid = 1'b1;
                  r_next.q_auto = 1'b0;
               end else begin
                  r_next = start_cmd(r_next, wr_data_i, 1'b0);
               end
            end
         end


         // Automatic alert or key sound, queue bit ignored
         // A host write in the same cycle was already refused
         if (auto_stb_i && r_reg.state != ST_SLEEP) begin
            if (r_next.state == ST_PLAY && r_next.act_auto) begin
               r_next.q_cmd = auto_cmd_i;
               r_next.q_valid = 1'b1;
               r_next.q_auto = 1'b1;
            end else begin
               r_next = start_cmd(r_next, auto_cmd_i, 1'b1);
               r_next.q_valid = 1'b0;
               r_next.q_auto = 1'b0;
            end
         end


         // Configuration run bit
         // Sleep keeps the pin level; wake acts only from real sleep
         if (cfg_wr_i) begin
            if (!run_not_sleep_bit_i) begin
               r_next.state = ST_SLEEP;
               r_next.act_auto = 1'b0;
               r_next.act_cmd = `CMD_RESET;
               r_next.q_valid = 1'b0;
               r_next.q_auto = 1'b0;
               r_next.snd = r_reg.snd;
            end else if (r_reg.state == ST_SLEEP) begin
               r_next.state = ST_IDLE;
               r_next.q_valid = 1'b0;
               r_next.q_auto = 1'b0;
               r_next.kfifo_clr = 1'b1;
            end
            // Already running: no queue or FIFO change
         end


         // Derived outputs
         r_next.keyscan_en = (r_next.state != ST_SLEEP);
         r_next.matrix_oe_n = {`MATRIX_LINES{r_next.state == ST_SLEEP}};
         r_next.int_n = int_gpo_sel_i ? r_next.general_purpose_output[`GPO_INT_BIT] : !r_next.irq;
         if (r_next.state == ST_PLAY) begin
            r_next.rd_data = {r_next.act_cmd[`CMD_DUR_HI:`CMD_LVL_BIT],
                              r_next.q_valid};
         end else begin
            r_next.rd_data = `CMD_RESET;
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Reset lands in run mode with the interrupt pin released
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r_reg <= '0;
         r_reg.state <= ST_IDLE;
         r_reg.int_n <= 1'b1;
         r_reg.keyscan_en <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Every output is a field of the one state register
   assign wr_ack_o = r_reg.wr_ack;
   assign wr_nack_o = r_reg.wr_nack;
   assign rd_data_o = r_reg.rd_data;
   assign keyscan_en_o = r_reg.keyscan_en;
   assign keyscan_fifo_clr_o = r_reg.kfifo_clr;
   assign matrix_line_oe_n_o = r_reg.matrix_oe_n;
   assign alert_status_o = r_reg.alert_status;
   assign irq_req_o = r_reg.irq;
   assign general_purpose_output_o = r_reg.general_purpose_output;
   assign int_n_o = r_reg.int_n;
   assign sounder_o = r_reg.snd;

endmodule

// File: testbench/tone_sounder_monitor.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Sounder port checker
// ---------------------------------------------------------------
module tone_sounder_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Inputs watched
   input wire logic ce_i,
   input wire logic wr_stb_i,
   input wire logic cfg_wr_i,
   input wire logic run_not_sleep_bit_i,
   input wire logic alert_i,
   input wire logic alert_irq_en_i,
   // Outputs watched
   input wire logic wr_ack_o,
   input wire logic wr_nack_o,
   input wire logic [7:0] rd_data_o,
   input wire logic keyscan_en_o,
   input wire logic keyscan_fifo_clr_o,
   input wire logic [15:0] matrix_line_oe_n_o,
   input wire logic alert_status_o,
   input wire logic irq_req_o,
   input wire logic sounder_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Two sleeping samples in a row
   sequence asleep_s;
      !keyscan_en_o ##1 !keyscan_en_o;
   endsequence
   // Sleep request taken
   sequence go_sleep_s;
      ce_i && cfg_wr_i && !run_not_sleep_bit_i;
   endsequence
   // Wake request taken while asleep
   sequence wake_s;
      ce_i && cfg_wr_i && run_not_sleep_bit_i && !keyscan_en_o;
   endsequence
   // Run bit rewritten while already running
   sequence run_rewrite_s;
      ce_i && cfg_wr_i && run_not_sleep_bit_i && keyscan_en_o;
   endsequence
   // Enabled alert rising against the stored status
   sequence alert_edge_s;
      ce_i && alert_irq_en_i && alert_i && !alert_status_o;
   endsequence
   write_answer_a: assert property (ce_i && wr_stb_i |=> wr_ack_o ^ wr_nack_o)
      else $error("write answer missing or doubled");
   sleep_ack_a: assert property (ce_i && wr_stb_i && !keyscan_en_o |=> wr_ack_o)
      else $error("write in sleep not acknowledged");
   sleep_lines_a: assert property (!keyscan_en_o |-> matrix_line_oe_n_o == 16'hFFFF)
      else $error("matrix lines driven in sleep");
   sleep_entry_a: assert property (go_sleep_s |=> !keyscan_en_o && rd_data_o == 8'h00)
      else $error("sleep entry incomplete");
   sleep_hold_a: assert property (asleep_s |-> $stable(sounder_o))
      else $error("sounder moved in sleep");
   wake_clear_a: assert property (wake_s |=> keyscan_fifo_clr_o && keyscan_en_o)
      else $error("wake without queue clear");
   rewrite_quiet_a: assert property (run_rewrite_s |=> !keyscan_fifo_clr_o)
      else $error("queue cleared while running");
   alert_copy_a: assert property (ce_i |=> alert_status_o == $past(alert_i))
      else $error("alert status not tracking");
   alert_irq_a: assert property (alert_edge_s |=> irq_req_o)
      else $error("alert edge raised no request");
endmodule

bind tone_sounder tone_sounder_monitor i_tone_sounder_monitor (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wr_stb_i(wr_stb_i), .cfg_wr_i(cfg_wr_i),
   .run_not_sleep_bit_i(run_not_sleep_bit_i), .alert_i(alert_i),
   .alert_irq_en_i(alert_irq_en_i), .wr_ack_o(wr_ack_o), .wr_nack_o(wr_nack_o),
   .rd_data_o(rd_data_o), .keyscan_en_o(keyscan_en_o), .keyscan_fifo_clr_o(keyscan_fifo_clr_o),
   .matrix_line_oe_n_o(matrix_line_oe_n_o), .alert_status_o(alert_status_o),
   .irq_req_o(irq_req_o), .sounder_o(sounder_o)
);

// File: testbench/piezo_listener.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Transducer stand-in: counts tone cycles, times high halves
// ---------------------------------------------------------------
module piezo_listener (
   // Clock and control
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic sounder_i,
   // Measurements
   output logic [7:0] rises_o,
   output logic [15:0] high_len_o
);
   logic prev_reg;
   logic [15:0] cnt_reg;
   // Edge count and high-half length
   always_ff @(posedge clk_i) begin
      prev_reg <= sounder_i;
      if (sounder_i && !prev_reg) begin
         cnt_reg <= 16'h0001;
      end else if (sounder_i) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
      if (!sounder_i && prev_reg) begin
         high_len_o <= cnt_reg;
      end
      if (clr_i) begin
         rises_o <= 8'h00;
      end else if (sounder_i && !prev_reg) begin
         rises_o <= rises_o + 8'h01;
      end
   end
endmodule

// File: testbench/tone_sounder_tb_top.sv
`timescale 1ns/1ps
module tone_sounder_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic wr_stb = 1'b0, auto_stb = 1'b0, cfg_wr = 1'b0, run_bit = 1'b1, alert = 1'b0;
   logic irq_en = 1'b0, irq_clr = 1'b0, gpo_wr = 1'b0, int_sel = 1'b0, clr = 1'b1;
   logic [7:0] wr_data = 8'h00, auto_cmd = 8'h00, rd, rises;
   logic [6:0] gpo_data = 7'h00, general_purpose_output;
   logic wr_ack, wr_nack, ks_en, ks_clr, alert_st, irq, int_n, snd;
   logic [15:0] oe_n, hi_len;
   int n_errors = 0;
   int checked = 0;
   int k, d;
   int chz [6] = '{131850, 156800, 176000, 209300, 234930, 263700};

   tone_sounder #(.MS_TICK_CYCLES(10)) i_tone_sounder (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wr_stb_i(wr_stb), .wr_data_i(wr_data),
      .wr_ack_o(wr_ack), .wr_nack_o(wr_nack), .rd_data_o(rd), .auto_stb_i(auto_stb),
      .auto_cmd_i(auto_cmd), .cfg_wr_i(cfg_wr), .run_not_sleep_bit_i(run_bit),
      .keyscan_en_o(ks_en), .keyscan_fifo_clr_o(ks_clr), .matrix_line_oe_n_o(oe_n),
      .alert_i(alert), .alert_irq_en_i(irq_en), .irq_clr_i(irq_clr),
      .alert_status_o(alert_st), .irq_req_o(irq), .gpo_wr_i(gpo_wr), .gpo_data_i(gpo_data),
      .int_gpo_sel_i(int_sel), .general_purpose_output_o(general_purpose_output), .int_n_o(int_n),
      .sounder_o(snd));
   piezo_listener i_piezo_listener (.clk_i(clk_i), .clr_i(clr), .sounder_i(snd),
      .rises_o(rises), .high_len_o(hi_len));

   always #50 clk_i = ~clk_i;

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Host write, answer one cycle later
   task automatic hwr(input logic [7:0] v, input logic nak);
      @(posedge clk_i);
      wr_stb <= 1'b1;
      wr_data <= v;
      @(posedge clk_i);
      wr_stb <= 1'b0;
      #1;
      chk(16'({wr_ack, wr_nack}), nak ? 16'h0001 : 16'h0002);
   endtask
   task automatic auto_snd(input logic [7:0] v);
      @(posedge clk_i);
      auto_stb <= 1'b1;
      auto_cmd <= v;
      @(posedge clk_i);
      auto_stb <= 1'b0;
      #1;
   endtask
   task automatic cfg(input logic b);
      @(posedge clk_i);
      cfg_wr <= 1'b1;
      run_bit <= b;
      @(posedge clk_i);
      cfg_wr <= 1'b0;
      #1;
   endtask
   task automatic finish_test();
      $display("mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      tick(90000);
      n_errors++;
      finish_test();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      tick(20);
      rst_i <= 1'b0;
      clr <= 1'b0;
      tick(1);
      #1;
      chk(16'(rd), 16'h0000);
      chk(16'({snd, int_n, ks_en}), 16'h0003);
      // Every upper tone code, high half against its frequency
      for (int i = 0; i < 6; i++) begin
         hwr(8'h00, 1'b0);
         hwr({3'h0, 4'(10 + i), 1'b0}, 1'b0);
         tick(2 * (500000000 / chz[i]) + 20);
         d = int'(hi_len) - 500000000 / chz[i];
         chk(16'(d >= -1 && d <= 1), 16'h0001);
      end
      hwr(8'h00, 1'b0);
      chk(16'(snd), 16'h0000);
      tick(1);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      // 500 ms tone ends after two whole cycles
      hwr(8'hDE, 1'b0);
      tick(9000);
      chk(16'(rises), 16'h0002);
      chk(16'({rd, 7'h00, snd}), 16'h0000);
      // Queue, then automatic sounds take over
      hwr(8'h1E, 1'b0);
      hwr(8'h9F, 1'b0);
      chk(16'(rd), 16'h001F);
      auto_snd(8'h14);
      chk(16'(rd), 16'h00F4);
      hwr(8'h02, 1'b1);
      chk(16'(rd), 16'h00F4);
      auto_snd(8'h81);
      auto_snd(8'h83);
      chk(16'(rd), 16'h00F5);
      for (k = 0; k < 20000 && rd === 8'hF5; k++) begin
         tick(1);
         #1;
      end
      chk(16'(k > 9000 && k < 20000), 16'h0001);
      chk(16'({rd, 7'h00, snd}), 16'h8201);
      tick(1300);
      chk(16'({rd, 7'h00, snd}), 16'h0000);
      hwr(8'h02, 1'b0);
      // Sleep with sounder held high
      cfg(1'b0);
      chk(16'(ks_en), 16'h0000);
      chk(oe_n, 16'hFFFF);
      chk(16'(rd), 16'h0000);
      hwr(8'h00, 1'b0);
      auto_snd(8'h14);
      tick(50);
      #1;
      chk(16'({rd, 7'h00, snd}), 16'h0001);
      tick(1);
      gpo_wr <= 1'b1;
      gpo_data <= 7'h2A;
      int_sel <= 1'b1;
      tick(1);
      gpo_wr <= 1'b0;
      tick(2);
      #1;
      chk(16'({general_purpose_output, int_n}), 16'h0054);
      tick(1);
      int_sel <= 1'b0;
      irq_en <= 1'b1;
      alert <= 1'b1;
      tick(3);
      #1;
      chk(16'({alert_st, irq, int_n}), 16'h0006);
      tick(1);
      irq_clr <= 1'b1;
      tick(1);
      irq_clr <= 1'b0;
      tick(2);
      #1;
      chk(16'({irq, int_n}), 16'h0001);
      // Wake clears queues, rewrite does not
      cfg(1'b1);
      chk(16'({ks_clr, ks_en}), 16'h0003);
      chk(oe_n, 16'h0000);
      cfg(1'b1);
      chk(16'(ks_clr), 16'h0000);
      // Enable low freezes the outputs, high lets the write land
      tick(1);
      ce_i <= 1'b0;
      gpo_wr <= 1'b1;
      gpo_data <= 7'h15;
      tick(2);
      #1;
      chk(16'(general_purpose_output), 16'h002A);
      tick(1);
      ce_i <= 1'b1;
      tick(1);
      gpo_wr <= 1'b0;
      #1;
      chk(16'(general_purpose_output), 16'h0015);
      finish_test();
   end
endmodule
